// file: src/spigp_pkg.sv
// package of constants and carrier types for the spi port with gpio mode
package spigp_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CONTROL   = 5'h00;
	localparam logic [4:0] REG_STATUS    = 5'h04;
	localparam logic [4:0] REG_TX_HOLD   = 5'h08;
	localparam logic [4:0] REG_RX_HOLD   = 5'h0c;
	localparam logic [4:0] REG_PULLUP    = 5'h10;
	localparam logic [4:0] REG_DIRECTION = 5'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_CLEAR  = 7;
	localparam int CTL_SELECT = 6;
	localparam int CTL_ROLE   = 5;
	localparam int CTL_FUNC   = 4;
	localparam int CTL_EDGE   = 3;
	localparam int CTL_IDLE   = 2;
	localparam int STS_OVR    = 2;
	localparam int STS_RDY    = 1;
	localparam int STS_FREE   = 0;
	localparam int PAD_NSS    = 3;
	localparam int PAD_MOSI   = 2;
	localparam int PAD_MISO   = 1;
	localparam int PAD_SCK    = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RST = 8'h68;
	localparam logic [7:0] DATA_RST    = 8'h00;
	localparam logic [3:0] PULLUP_RST  = 4'hf;
	localparam logic [3:0] DIR_RST     = 4'h0;

	// ----------------------------------------------------------------
	// timing: half periods in rc clock enables, 4 khz from sys clock
	// ----------------------------------------------------------------
	localparam int  SYS_HZ        = 40000000;
	localparam int  FIXED_SCK_HZ  = 4000;
	localparam int  FIXED_HALF    = SYS_HZ / (2 * FIXED_SCK_HZ);
	localparam logic [12:0] FIXED_HALF_CYC = 13'(FIXED_HALF);
	localparam logic [12:0] HALF_DIV2  = 13'h0001;
	localparam logic [12:0] HALF_DIV8  = 13'h0004;
	localparam logic [12:0] HALF_DIV16 = 13'h0008;
	localparam logic [3:0]  BIT_COUNT  = 4'h8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_DIV2  = 2'b00,
		RATE_DIV8  = 2'b01,
		RATE_DIV16 = 2'b10,
		RATE_4KHZ  = 2'b11
	} spigp_rate_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_TRAIL = 2'b10
	} spigp_state_type;

	// pad bundle, bits mapped nss/mosi/miso/sck = 3..0
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
		logic [3:0] pu;
	} spigp_pad_type;

endpackage

// file: src/spigp_top.sv
// spi peripheral with 4-bit general purpose port mode, avalon slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module spigp_top (
	// system
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        pconf_rstn,
	input  wire logic        rc_source_clock,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// pads, bits nss/mosi/miso/sck
	input  wire logic [3:0]  pad_in,
	output spigp_pkg::spigp_pad_type pad_ff,
	// receive interrupt
	output logic             rx_irq_ff
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  ctl_ff;
	logic [7:0]  tx_ff;
	logic [7:0]  rx_ff;
	logic [7:0]  sh_ff;
	logic [3:0]  pu_ff;
	logic [3:0]  dir_ff;
	logic        ovr_ff;
	logic        rdy_ff;
	logic        free_ff;
	logic        loaded_ff;
	logic [3:0]  sync1_ff;
	logic [3:0]  sync2_ff;
	logic [3:0]  sync3_ff;
	logic [1:0]  rc1_ff;
	logic        rc2_ff;
	logic        rc3_ff;
	logic [12:0] div_ff;
	logic [3:0]  cnt_ff;
	logic        sck_ff;
	logic        smp_ff;
	logic        ack_ff;
	logic        out_ff;
	spigp_pkg::spigp_state_type st_ff;

	// ----------------------------------------------------------------
	// bus decode; one cycle answer via ack_ff, access acts at answer edge
	// ----------------------------------------------------------------
	wire req      = (avs_read | avs_write) & ~ack_ff;
	wire wr_hit   = avs_write & ack_ff & avs_byteenable[0];
	wire rd_hit   = avs_read & ack_ff;
	wire wr_ctl   = wr_hit & (avs_address == spigp_pkg::REG_CONTROL);
	wire wr_sts   = wr_hit & (avs_address == spigp_pkg::REG_STATUS);
	wire wr_tx    = wr_hit & (avs_address == spigp_pkg::REG_TX_HOLD);
	wire wr_pu    = wr_hit & (avs_address == spigp_pkg::REG_PULLUP);
	wire wr_dir   = wr_hit & (avs_address == spigp_pkg::REG_DIRECTION);
	wire rd_rx    = rd_hit & (avs_address == spigp_pkg::REG_RX_HOLD);
	wire [7:0] wd = avs_writedata[7:0];

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	wire spi_on   = ctl_ff[spigp_pkg::CTL_FUNC];
	wire master   = ctl_ff[spigp_pkg::CTL_ROLE];
	wire idle_lvl = ctl_ff[spigp_pkg::CTL_IDLE];
	wire edge1    = ctl_ff[spigp_pkg::CTL_EDGE];
	wire clr_cnt  = wr_ctl & wd[spigp_pkg::CTL_CLEAR];
	wire ld_cmd   = wr_sts & wd[spigp_pkg::STS_FREE];
	wire nss_in   = sync2_ff[spigp_pkg::PAD_NSS];
	wire sck_in   = sync2_ff[spigp_pkg::PAD_SCK];
	wire sck_lvl  = sck_in ^ idle_lvl;
	wire sck_prev = sync3_ff[spigp_pkg::PAD_SCK] ^ idle_lvl;
	// slave edges: lead = leaving idle, trail = back to idle
	wire s_lead   = sck_lvl & ~sck_prev;
	wire s_trail  = ~sck_lvl & sck_prev;
	wire s_hold   = nss_in | clr_cnt;
	wire miso_in  = sync2_ff[spigp_pkg::PAD_MISO];
	wire mosi_in  = sync2_ff[spigp_pkg::PAD_MOSI];
	wire ser_in   = master ? miso_in : mosi_in;

	// ----------------------------------------------------------------
	// rate divider: rc clock is synchronised, its rising edge is the tick
	// ----------------------------------------------------------------
	wire rc_tick  = rc2_ff & ~rc3_ff;
	spigp_pkg::spigp_rate_type rate;
	assign rate   = spigp_pkg::spigp_rate_type'(ctl_ff[1:0]);
	logic [12:0] half;
	always_comb begin
		unique case (rate)
			spigp_pkg::RATE_DIV2:  half = spigp_pkg::HALF_DIV2;
			spigp_pkg::RATE_DIV8:  half = spigp_pkg::HALF_DIV8;
			spigp_pkg::RATE_DIV16: half = spigp_pkg::HALF_DIV16;
			spigp_pkg::RATE_4KHZ:  half = spigp_pkg::FIXED_HALF_CYC;
		endcase
	end
	wire fixed    = (rate == spigp_pkg::RATE_4KHZ);
	wire div_step = fixed | rc_tick;
	wire half_end = div_step & (div_ff == half - 13'h0001);
	wire m_run    = master & (st_ff != spigp_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// shift engine events, unified for both roles
	// ----------------------------------------------------------------
	wire m_lead   = m_run & half_end & (st_ff == spigp_pkg::ST_LEAD);
	wire m_trail  = m_run & half_end & (st_ff == spigp_pkg::ST_TRAIL);
	wire ev_lead  = master ? m_lead : (s_lead & ~s_hold);
	wire ev_trail = master ? m_trail : (s_trail & ~s_hold);
	// edge select 1: sample on lead, shift on trail; 0 the reverse
	wire ev_smp   = edge1 ? ev_lead : ev_trail;
	wire ev_sft   = edge1 ? ev_trail : ev_lead;
	wire last     = (cnt_ff == spigp_pkg::BIT_COUNT - 4'h1);
	// byte done when the eighth closing edge passes
	wire done     = spi_on & ev_trail & last;
	wire m_start  = spi_on & master & ld_cmd;
	wire slv_ld   = ~master & done & loaded_ff;
	wire tx_move  = (spi_on & ld_cmd) | slv_ld;
	// rotated byte with the sample of this transfer in the lsb
	wire [7:0] rot = edge1 ? {sh_ff[6:0], smp_ff}
	                       : {sh_ff[6:0], ser_in};

	// ----------------------------------------------------------------
	// bus answer and read mux
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		unique case (avs_address)
			spigp_pkg::REG_CONTROL:   rd_mux = {1'b0, ctl_ff[6:0]};
			spigp_pkg::REG_STATUS:    rd_mux = {5'h00, ovr_ff, rdy_ff,
			                                    free_ff};
			spigp_pkg::REG_TX_HOLD:   rd_mux = tx_ff;
			spigp_pkg::REG_RX_HOLD:   rd_mux = spi_on ? rx_ff
			                            : {4'h0, sync2_ff};
			spigp_pkg::REG_PULLUP:    rd_mux = {4'h0, pu_ff};
			spigp_pkg::REG_DIRECTION: rd_mux = {4'h0, dir_ff};
			default:                  rd_mux = 8'h00;  // unmapped reads 0
		endcase
	end

	// request taken in first cycle, waitrequest dropped in the second
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ack_ff          <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			ack_ff          <= req;
			avs_waitrequest <= ~req;
			avs_readdata    <= {24'h00_0000, rd_mux};
		end
	end

	// ----------------------------------------------------------------
	// control and data registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctl_ff <= spigp_pkg::CONTROL_RST;
			tx_ff  <= spigp_pkg::DATA_RST;
		end else begin
			if (wr_ctl)
				ctl_ff <= {1'b0, wd[6:0]};
			if (wr_tx)
				tx_ff <= wd;
		end
	end

	// pad configuration has its own reset
	always_ff @(posedge clk_sys) begin
		if (!pconf_rstn) begin
			pu_ff  <= spigp_pkg::PULLUP_RST;
			dir_ff <= spigp_pkg::DIR_RST;
		end else begin
			if (wr_pu)
				pu_ff <= wd[3:0];
			if (wr_dir)
				dir_ff <= wd[3:0];
		end
	end

	// ----------------------------------------------------------------
	// status flags; hardware set wins over software clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ovr_ff    <= 1'b0;
			rdy_ff    <= 1'b0;
			free_ff   <= 1'b1;
			loaded_ff <= 1'b0;
			rx_irq_ff <= 1'b0;
		end else begin
			if (done & rdy_ff & ~rd_rx)
				ovr_ff <= 1'b1;
			else if (wr_sts & wd[spigp_pkg::STS_OVR])
				ovr_ff <= 1'b0;
			if (done)
				rdy_ff <= 1'b1;
			else if (rd_rx)
				rdy_ff <= 1'b0;
			if (tx_move)
				free_ff <= 1'b1;
			else if (wr_tx)
				free_ff <= 1'b0;
			if (spi_on & ld_cmd)
				loaded_ff <= 1'b1;
			rx_irq_ff <= done & ~rdy_ff;
		end
	end

	// ----------------------------------------------------------------
	// synchronisers: pads pass two flip-flops, rc clock three
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			sync3_ff <= 4'h0;
			rc1_ff   <= 2'b00;
			rc2_ff   <= 1'b0;
			rc3_ff   <= 1'b0;
		end else begin
			sync1_ff <= pad_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			rc1_ff   <= {rc1_ff[0], rc_source_clock};
			rc2_ff   <= rc1_ff[1];
			rc3_ff   <= rc2_ff;
		end
	end

	// ----------------------------------------------------------------
	// master sequencer: idle, leading half, trailing half
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_ff  <= spigp_pkg::ST_IDLE;
			div_ff <= 13'h0000;
			sck_ff <= 1'b0;
		end else begin
			if (m_start | clr_cnt | ~master | ~spi_on) begin
				// clear restarts the byte if one was running
				st_ff  <= (m_start | (clr_cnt & m_run))
				          ? spigp_pkg::ST_LEAD : spigp_pkg::ST_IDLE;
				div_ff <= 13'h0000;
				sck_ff <= 1'b0;
			end else if (m_run & div_step) begin
				div_ff <= half_end ? 13'h0000 : div_ff + 13'h0001;
				if (half_end) begin
					unique case (st_ff)
						spigp_pkg::ST_LEAD: begin
							st_ff  <= spigp_pkg::ST_TRAIL;
							sck_ff <= 1'b1;
						end
						spigp_pkg::ST_TRAIL: begin
							// clock stops after the last bit
							st_ff  <= last ? spigp_pkg::ST_IDLE
							               : spigp_pkg::ST_LEAD;
							sck_ff <= 1'b0;
						end
						default: st_ff <= spigp_pkg::ST_IDLE;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// shift register and bit counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sh_ff  <= spigp_pkg::DATA_RST;
			rx_ff  <= spigp_pkg::DATA_RST;
			cnt_ff <= 4'h0;
			smp_ff <= 1'b0;
			out_ff <= 1'b0;
		end else begin
			if (ev_smp)
				smp_ff <= ser_in;
			// edge select 0: the bit leaving at the lead edge must stay
			// on the wire until the far side samples it at the trail
			if (ev_sft & spi_on & ~edge1)
				out_ff <= sh_ff[7];
			if (m_start | clr_cnt | (~master & nss_in))
				cnt_ff <= 4'h0;
			else if (ev_trail)
				cnt_ff <= last ? 4'h0 : cnt_ff + 4'h1;
			if (done)
				rx_ff <= rot;
			if (tx_move)
				sh_ff <= tx_ff;
			else if (ev_sft & ~(edge1 & done) & spi_on)
				sh_ff <= rot;
			else if (edge1 & done)
				sh_ff <= rot;
		end
	end

	// ----------------------------------------------------------------
	// pad drive: spi roles or port registers
	// ----------------------------------------------------------------
	// with edge select 1 the first bit must be on mosi before the
	// first edge, so the msb is driven straight from the shifter
	wire [3:0] spi_oe = master ? 4'b1101 : 4'b0010;
	wire       sck_o  = sck_ff ^ idle_lvl;
	wire       ser_o  = edge1 ? sh_ff[7] : out_ff;
	wire [3:0] spi_o  = {ctl_ff[spigp_pkg::CTL_SELECT],
	                     ser_o, ser_o, sck_o};
	wire [3:0] oe_sel = spi_on ? spi_oe : dir_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pad_ff <= '0;
		end else begin
			pad_ff.o  <= spi_on ? spi_o : tx_ff[3:0];
			pad_ff.oe <= oe_sel;
			pad_ff.pu <= pu_ff & ~oe_sel;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_load;
		spi_on & master & ld_cmd;
	endsequence
	sequence s_busy;
		st_ff == spigp_pkg::ST_LEAD;
	endsequence

	chk_master_start: assert property (@(posedge clk_sys)
		disable iff (!rstn) s_load |=> s_busy ##0 free_ff)
		else $error("master load did not start transfer");
	chk_rx_ready_set: assert property (@(posedge clk_sys)
		disable iff (!rstn) done |=> rdy_ff)
		else $error("rx ready not set after byte");
	chk_rx_read_clr: assert property (@(posedge clk_sys)
		disable iff (!rstn) rd_rx & ~done |=> ~rdy_ff)
		else $error("rx ready not cleared by read");
	chk_overrun_set: assert property (@(posedge clk_sys)
		disable iff (!rstn) done & rdy_ff & ~rd_rx |=> ovr_ff)
		else $error("overrun not flagged");
	chk_tx_free_clr: assert property (@(posedge clk_sys)
		disable iff (!rstn) wr_tx & ~tx_move |=> ~free_ff)
		else $error("tx free not cleared on write");
	chk_irq_pulse: assert property (@(posedge clk_sys)
		disable iff (!rstn) rx_irq_ff |-> $rose(rdy_ff))
		else $error("irq without ready rising");
	chk_pullup_off: assert property (@(posedge clk_sys)
		disable iff (!rstn) (pad_ff.pu & pad_ff.oe) == 4'h0)
		else $error("pull-up on driven pad");
	chk_slave_hold: assert property (@(posedge clk_sys)
		disable iff (!rstn) ~master & nss_in |=> cnt_ff == 4'h0)
		else $error("slave counter runs while nss high");
	chk_sck_stop: assert property (@(posedge clk_sys)
		disable iff (!rstn) master & done |=> ##1
		(st_ff == spigp_pkg::ST_IDLE) [*2])
		else $error("master clock did not stop");

endmodule

// file: dv/spigp_ext_slave.sv
// behavioural external spi slave that faces the block in master mode
`timescale 1ns/1ps
module spigp_ext_slave (
	// control from the bench
	input  wire logic       en,
	input  wire logic       idle,
	input  wire logic       edge_sel,
	input  wire logic [7:0] tx_byte,
	// spi wires
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       nss,
	output logic            miso,
	output logic            miso_oe,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh;

	// miso is released while deselected so a stale bit cannot pass
	assign miso_oe = en & ~nss;
	initial begin
		miso = 1'b0;
		sh = 8'h00;
		rx_byte = 8'h00;
	end
	// load at select; with edge 1 the first bit leads the clock
	always @(negedge nss) begin
		sh = tx_byte;
		rx_byte = 8'h00;
		if (edge_sel) begin
			miso = sh[7];
			sh = sh << 1;
		end
	end
	// one edge samples, the other shifts, msb first
	always @(sck) begin
		if (en && !nss) begin
			if ((sck != idle) == edge_sel) begin
				rx_byte = {rx_byte[6:0], mosi};
			end else begin
				miso = sh[7];
				sh = sh << 1;
			end
		end
	end
endmodule

// file: dv/spigp_top_bench.sv
// self-checking bench for the spi port with gpio mode
`timescale 1ns/1ps
module spigp_top_bench;
	// ------
	// signals
	// ------
	localparam int         RC_CYC = 4;
	localparam logic [4:0] ADDRS [7] = '{5'h00, 5'h04, 5'h08, 5'h0c,
		5'h10, 5'h14, 5'h18};
	localparam logic [7:0] RSTV [7] = '{8'h68, 8'h01, 8'h00, 8'h0f,
		8'h0f, 8'h00, 8'h00};
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        pconf_rstn = 1'b0;
	logic        rc_source_clock = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  pad_in;
	spigp_pkg::spigp_pad_type pad_ff;
	logic        rx_irq_ff;
	logic [3:0]  drv_oe = 4'h0;
	logic [3:0]  drv_o;
	logic        x_nss = 1'b1;
	logic        x_mosi = 1'b0;
	logic        x_miso = 1'b0;
	logic        x_sck = 1'b0;
	logic [3:0]  float_ff = 4'h5;
	logic        s_en = 1'b0;
	logic        s_idle = 1'b0;
	logic        s_edge = 1'b1;
	logic [7:0]  s_tx = 8'h00;
	logic        miso;
	logic        miso_oe;
	logic [7:0]  s_rx;
	logic        sck_prev = 1'b0;
	int          failures = 0;
	int          cmp_count = 0;
	int          irq_cnt = 0;
	int          half_cnt = 0;
	int          half_last = 0;
	int          sck_edges = 0;
	logic [31:0] rnd = 32'h6b19;

	// 40 mhz system clock, rc clock of four system periods
	always #12.5 clk_sys = ~clk_sys;
	always #50 rc_source_clock = ~rc_source_clock;
	assign drv_o = {x_nss, x_mosi, x_miso, x_sck};
	// wire level; an undriven line without pull-up toggles every cycle
	for (genvar i = 0; i < 4; i++) begin : g_wire
		assign pad_in[i] = pad_ff.oe[i] ? pad_ff.o[i] :
			(i == 1 && miso_oe) ? miso : drv_oe[i] ? drv_o[i] :
			pad_ff.pu[i] ? 1'b1 : float_ff[i];
	end
	// monitor of irq pulses and serial clock half periods
	always @(posedge clk_sys) begin
		float_ff <= ~float_ff;
		sck_prev <= pad_ff.o[0];
		if (rx_irq_ff === 1'b1)
			irq_cnt <= irq_cnt + 1;
		if (pad_ff.o[0] !== sck_prev) begin
			half_last <= half_cnt;
			half_cnt <= 1;
			sck_edges <= sck_edges + 1;
		end else begin
			half_cnt <= half_cnt + 1;
		end
	end

	spigp_top spigp_top_i (.clk_sys(clk_sys), .rstn(rstn),
		.pconf_rstn(pconf_rstn), .rc_source_clock(rc_source_clock),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
		.pad_ff(pad_ff), .rx_irq_ff(rx_irq_ff));
	spigp_ext_slave spigp_ext_slave_i (.en(s_en), .idle(s_idle),
		.edge_sel(s_edge), .tx_byte(s_tx), .sck(pad_in[0]),
		.mosi(pad_in[2]), .nss(pad_in[3]), .miso(miso),
		.miso_oe(miso_oe), .rx_byte(s_rx));

	// ------
	// tasks
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check($sformatf("reg %h", a), q, {24'h0, e});
	endtask
	// irq only when the ready flag rises, not when it was already set
	task automatic wait_irq(input int n0, input int e0, input int inc);
		int n;
		n = 0;
		while (irq_cnt == n0 && sck_edges - e0 < 16 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (8) @(posedge clk_sys);
		if (n >= 4000)
			failures++;
		check("irq count", irq_cnt, n0 + inc);
	endtask
	// one master byte; odd passes leave the previous byte unread
	task automatic master_byte(input int i, input logic [7:0] d,
		input logic [7:0] sb);
		logic [1:0] rt;
		logic [7:0] ctl;
		int e0;
		int n0;
		rt = (i == 3) ? 2'b00 : 2'(i);
		ctl = {4'h3, i[1], i[0], rt};
		s_idle <= i[0];
		s_edge <= i[1];
		s_tx <= sb;
		wr(5'h00, ctl | 8'h40);
		wr(5'h08, d);
		rd(5'h04, i[0] ? 8'h02 : 8'h00);
		wr(5'h00, ctl);
		check("nss level", pad_ff.o[3], 1'b0);
		check("master oe", pad_ff.oe, 4'hd);
		check("sck idle", pad_ff.o[0], i[0]);
		e0 = sck_edges;
		n0 = irq_cnt;
		wr(5'h04, 8'h01);
		wait_irq(n0, e0, i[0] ? 0 : 1);
		check("sck edges", sck_edges - e0, 16);
		check("sck half", half_last,
			(rt == 0 ? 2 : rt == 1 ? 8 : 16) * RC_CYC / 2);
		check("sck rest", pad_ff.o[0], i[0]);
		check("slave rx", s_rx, d);
		rd(5'h04, i[0] ? 8'h07 : 8'h03);
		if (i[0]) begin
			rd(5'h0c, sb);
			rd(5'h04, 8'h05);
			wr(5'h04, 8'h04);
		end
		wr(5'h00, ctl | 8'h40);
	endtask
	// bench as external master, each sck level six cycles
	task automatic ext_byte(input logic [7:0] m, output logic [7:0] got);
		x_sck <= 1'b1;
		repeat (6) @(posedge clk_sys);
		x_sck <= 1'b0;
		repeat (6) @(posedge clk_sys);
		x_nss <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			x_mosi <= m[b];
			repeat (6) @(posedge clk_sys);
			got[b] = pad_in[1];
			x_sck <= 1'b1;
			repeat (6) @(posedge clk_sys);
			x_sck <= 1'b0;
		end
		repeat (6) @(posedge clk_sys);
		x_nss <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask

	// ------
	// sequence
	// ------
	initial begin
		logic [7:0] got;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		pconf_rstn <= 1'b1;
		@(posedge clk_sys);
		for (int k = 0; k < 7; k++)
			rd(ADDRS[k], RSTV[k]);
		wr(5'h00, 8'hff);
		rd(5'h00, 8'h7f);
		wr(5'h00, 8'h68);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			if (k == 0)
				rnd[3:0] = 4'hf;
			drv_oe <= ~rnd[3:0];
			{x_nss, x_mosi, x_miso, x_sck} <= rnd[19:16];
			wr(5'h14, {4'h0, rnd[3:0]});
			wr(5'h08, rnd[11:4]);
			wr(5'h10, {4'h0, rnd[15:12]});
			repeat (4) @(posedge clk_sys);
			check("pad oe", pad_ff.oe, rnd[3:0]);
			check("pad o", pad_ff.o & rnd[3:0], rnd[7:4] & rnd[3:0]);
			check("pad pu", pad_ff.pu, rnd[15:12] & ~rnd[3:0]);
			rd(5'h14, {4'h0, rnd[3:0]});
			rd(5'h0c, {4'h0, (rnd[3:0] & rnd[7:4]) |
				(~rnd[3:0] & rnd[19:16])});
		end
		drv_oe <= 4'h0;
		x_nss <= 1'b1;
		x_sck <= 1'b0;
		wr(5'h14, 8'h00);
		wr(5'h10, 8'h0f);
		s_en <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			master_byte(i, (i == 0) ? 8'h80 : rnd[7:0], rnd[15:8]);
		end
		s_en <= 1'b0;
		wr(5'h00, 8'h18);
		rnd = lfsr(rnd);
		wr(5'h08, rnd[7:0]);
		wr(5'h04, 8'h01);
		wr(5'h08, rnd[15:8]);
		rd(5'h04, 8'h00);
		check("slave oe", pad_ff.oe & 4'hd, 4'h0);
		drv_oe <= 4'hd;
		for (int b = 0; b < 2; b++) begin
			ext_byte(b ? rnd[31:24] : rnd[23:16], got);
			check("master rx", got, b ? rnd[15:8] : rnd[7:0]);
			rd(5'h04, 8'h03);
			rd(5'h0c, b ? rnd[31:24] : rnd[23:16]);
		end
		tally_and_finish();
	end
	// watchdog over the whole expected run
	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		tally_and_finish();
	end
endmodule
